// ### rtl/override_drive.sv
`timescale 1ns/100ps
module override_drive
(
	input wire logic [1:0] level_i,
	input wire logic inactive_i,
	output logic pin_o,
	output logic pin_oe_o
);
	// inactive level is the deasserted polarity of the output
	wire force_w = (level_i == shutdown_pkg::lvl_high);
	wire float_w = (level_i == shutdown_pkg::lvl_tristate);
	wire drive_low_w = (level_i == shutdown_pkg::lvl_low);
	assign pin_o = force_w ? 1'b1 : (drive_low_w ? 1'b0 : inactive_i);
	assign pin_oe_o = !float_w;
endmodule

// ### rtl/shutdown_pkg.sv
// Function
// - software shutdown request forces override levels
// - no restart: shutdown holds while flag set
// - restart enabled: hardware clears flag, resumes
// - flag shows shutdown; software, hardware set/clear
// - enabled active source overrides outputs at once
// - two-bit fields set B/D and A/C levels
// - six shutdown sources are active low
// - each source has own enable bit
// - sources level sensitive; active level blocks clear
// - every shutdown event raises interrupt flag; code raises it only if flag clear
// - restart only after source removed or disabled
// - restart enabled: hardware clears when faults gone
// - resume only at next data rising edge
// - software clear ignored while condition present
package shutdown_pkg;
	localparam int num_sources = 6;
	// source enable bit positions
	localparam int src_pin = 0;
	localparam int src_tmr2 = 1;
	localparam int src_tmr4 = 2;
	localparam int src_tmr6 = 3;
	localparam int src_cmp1 = 4;
	localparam int src_cmp2 = 5;
	// override level codes
	localparam logic [1:0] lvl_inactive = 2'h0;
	localparam logic [1:0] lvl_tristate = 2'h1;
	localparam logic [1:0] lvl_low = 2'h2;
	localparam logic [1:0] lvl_high = 2'h3;
	localparam logic [1:0] level_reset = 2'h0;
	localparam logic [num_sources-1:0] enable_reset = 6'h00;
	localparam logic [num_sources-1:0] src_idle_n = 6'h3f;
	localparam logic data_idle = 1'h0;
	localparam logic flag_reset = 1'h0;
	typedef enum logic [2:0]
	{
		st_run = 3'h1,
		st_shut = 3'h2,
		st_wait_edge = 3'h4
	} shut_state_t;
endpackage

// ### rtl/waveform_auto_shutdown.sv
`timescale 1ns/100ps
module waveform_auto_shutdown
(
	input wire logic clock_i,
	input wire logic rst_i,
	// waveform generator outputs in normal operation
	input wire logic wave_a_i,
	input wire logic wave_b_i,
	input wire logic wave_c_i,
	input wire logic wave_d_i,
	input wire logic data_in_i,
	// output polarities (inactive level for override code 0)
	input wire logic inactive_a_i,
	input wire logic inactive_b_i,
	input wire logic inactive_c_i,
	input wire logic inactive_d_i,
	// active-low shutdown sources
	input wire logic shutdown_pin_n_i,
	input wire logic tmr2_post_n_i,
	input wire logic tmr4_post_n_i,
	input wire logic tmr6_post_n_i,
	input wire logic cmp1_out_n_i,
	input wire logic cmp2_out_n_i,
	// shutdown control bits
	input wire logic [5:0] source_enable_bits_i,
	input wire logic [1:0] override_level_bd_i,
	input wire logic [1:0] override_level_ac_i,
	input wire logic restart_enable_i,
	input wire logic shutdown_set_i,
	input wire logic shutdown_clear_i,
	input wire logic irq_clear_i,
	output logic shutdown_flag_o,
	output logic shutdown_irq_flag_o,
	output logic override_active_o,
	output logic out_a_o,
	output logic out_a_oe_o,
	output logic out_b_o,
	output logic out_b_oe_o,
	output logic out_c_o,
	output logic out_c_oe_o,
	output logic out_d_o,
	output logic out_d_oe_o
);
	// ----------------------------------------
	// source conditioning
	// ----------------------------------------
	// the raw pin levels are used unsynchronised for the override path only, so
	// the fault reaches the outputs without waiting for a clock edge
	logic [5:0] raw_n;
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic data_sync1_q;
	logic data_sync2_q;
	logic data_prev_q;

	// bit order follows the enable field
	assign raw_n[shutdown_pkg::src_pin] = shutdown_pin_n_i;
	assign raw_n[shutdown_pkg::src_tmr2] = tmr2_post_n_i;
	assign raw_n[shutdown_pkg::src_tmr4] = tmr4_post_n_i;
	assign raw_n[shutdown_pkg::src_tmr6] = tmr6_post_n_i;
	assign raw_n[shutdown_pkg::src_cmp1] = cmp1_out_n_i;
	assign raw_n[shutdown_pkg::src_cmp2] = cmp2_out_n_i;

	// synchronisers reset to the idle level, so no false fault follows reset
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_q <= shutdown_pkg::src_idle_n;
		end
		else
		begin
			sync1_q <= raw_n;
		end
	end

	// only this stage is read by the flag logic
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync2_q <= shutdown_pkg::src_idle_n;
		end
		else
		begin
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_sync1_q <= shutdown_pkg::data_idle;
		end
		else
		begin
			data_sync1_q <= data_in_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_sync2_q <= shutdown_pkg::data_idle;
		end
		else
		begin
			data_sync2_q <= data_sync1_q;
		end
	end

	// the edge history follows the second stage only
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_prev_q <= shutdown_pkg::data_idle;
		end
		else
		begin
			data_prev_q <= data_sync2_q;
		end
	end

	function automatic logic any_active(input logic [5:0] lvl_n, input logic [5:0] en);
		any_active = |(~lvl_n & en);
	endfunction

	// async fault view feeds only the output override
	wire fault_async_w = any_active(raw_n, source_enable_bits_i);
	// clocked fault view drives the flag, level sensitive
	wire fault_sync_w = any_active(sync2_q, source_enable_bits_i);
	wire data_rise_w = data_sync2_q && !data_prev_q;

	// ----------------------------------------
	// shutdown flag and state
	// ----------------------------------------
	shutdown_pkg::shut_state_t state_q;
	shutdown_pkg::shut_state_t state_d;
	logic flag_q;
	logic flag_d;
	logic irq_q;
	logic irq_d;

	// ----------------------------------------
	// restart qualification
	// ----------------------------------------
	wire set_event_w = shutdown_set_i || fault_sync_w;
	// clearing is only possible once every enabled source has gone
	wire may_clear_w = !fault_sync_w && !shutdown_set_i;
	wire sw_clear_w = shutdown_clear_i && !restart_enable_i && may_clear_w;
	wire hw_clear_w = restart_enable_i && may_clear_w;

	always_comb
	begin
		flag_d = flag_q;
		// set wins, so a fault that returns in the clearing cycle is never lost
		if (set_event_w)
			flag_d = 1'b1;
		else if (flag_q && (sw_clear_w || hw_clear_w))
			flag_d = 1'b0;
	end

	// ----------------------------------------
	// interrupt flag
	// ----------------------------------------
	// a new shutdown event wins over a clear in the same cycle
	wire new_event_w = set_event_w && !flag_q;
	assign irq_d = new_event_w ? 1'b1 : (irq_clear_i ? 1'b0 : irq_q);

	// ----------------------------------------
	// state sequencing
	// ----------------------------------------
	// outputs leave the forced levels only from the run state
	wire in_run_w = (state_q == shutdown_pkg::st_run);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			shutdown_pkg::st_run:
			begin
				if (flag_d)
					state_d = shutdown_pkg::st_shut;
			end
			shutdown_pkg::st_shut:
			begin
				if (!flag_d)
					state_d = shutdown_pkg::st_wait_edge;
			end
			shutdown_pkg::st_wait_edge:
			begin
				// a new event here goes back to shut without resuming
				if (flag_d)
					state_d = shutdown_pkg::st_shut;
				else if (data_rise_w)
					state_d = shutdown_pkg::st_run;
			end
			default:
				state_d = shutdown_pkg::st_shut;
		endcase
	end

	// flag and state share an edge, so the state never lags the flag
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= shutdown_pkg::st_run;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			flag_q <= shutdown_pkg::flag_reset;
		end
		else
		begin
			flag_q <= flag_d;
		end
	end

	// sticky until software clears it
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_q <= shutdown_pkg::flag_reset;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------
	// output override
	// ----------------------------------------
	// the request input is folded in directly so software shutdown is also immediate;
	// raw pins reach the outputs unfiltered, so a glitch on an enabled source forces them too
	wire override_w = fault_async_w || shutdown_set_i || !in_run_w;
	logic [3:0] ovr_pin;
	logic [3:0] ovr_oe;

	// normal levels pass untouched; the forced level replaces them only while overridden
	function automatic logic steer(input logic ovr, input logic forced, input logic normal);
		steer = ovr ? forced : normal;
	endfunction

	override_drive drive_a
	(
		.level_i(override_level_ac_i),
		.inactive_i(inactive_a_i),
		.pin_o(ovr_pin[0]),
		.pin_oe_o(ovr_oe[0])
	);
	override_drive drive_b
	(
		.level_i(override_level_bd_i),
		.inactive_i(inactive_b_i),
		.pin_o(ovr_pin[1]),
		.pin_oe_o(ovr_oe[1])
	);
	override_drive drive_c
	(
		.level_i(override_level_ac_i),
		.inactive_i(inactive_c_i),
		.pin_o(ovr_pin[2]),
		.pin_oe_o(ovr_oe[2])
	);
	override_drive drive_d
	(
		.level_i(override_level_bd_i),
		.inactive_i(inactive_d_i),
		.pin_o(ovr_pin[3]),
		.pin_oe_o(ovr_oe[3])
	);

	// a and c share the ac field, b and d the bd field
	assign out_a_o = steer(override_w, ovr_pin[0], wave_a_i);
	assign out_b_o = steer(override_w, ovr_pin[1], wave_b_i);
	assign out_c_o = steer(override_w, ovr_pin[2], wave_c_i);
	assign out_d_o = steer(override_w, ovr_pin[3], wave_d_i);

	// a floated output drops its enable only while overridden
	assign out_a_oe_o = steer(override_w, ovr_oe[0], 1'h1);
	assign out_b_oe_o = steer(override_w, ovr_oe[1], 1'h1);
	assign out_c_oe_o = steer(override_w, ovr_oe[2], 1'h1);
	assign out_d_oe_o = steer(override_w, ovr_oe[3], 1'h1);

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	assign override_active_o = override_w;
	assign shutdown_flag_o = flag_q;
	assign shutdown_irq_flag_o = irq_q;
endmodule

// ### verification/fault_stage_model.sv
`timescale 1ns/100ps
module fault_stage_model
(
	input wire logic [5:0] fault_i,
	input wire logic pulse_i,
	output logic [5:0] src_n_o,
	output logic data_o
);
	assign src_n_o = ~fault_i;
	assign data_o = pulse_i;
endmodule

// ### verification/shutdown_chk.sv
`timescale 1ns/100ps
module shutdown_chk
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic shutdown_pin_n_i,
	input wire logic cmp1_out_n_i,
	input wire logic [5:0] source_enable_bits_i,
	input wire logic [1:0] override_level_ac_i,
	input wire logic restart_enable_i,
	input wire logic shutdown_set_i,
	input wire logic shutdown_clear_i,
	input wire logic shutdown_flag_o,
	input wire logic shutdown_irq_flag_o,
	input wire logic override_active_o,
	input wire logic out_a_o,
	input wire logic out_a_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// fault must outlast the two sync stages
	sequence s_held; (!cmp1_out_n_i && source_enable_bits_i[4])[*3]; endsequence
	property p_set; shutdown_set_i |-> override_active_o; endproperty
	a_set: assert property (p_set) else $error("set");
	property p_flag; shutdown_set_i |=> shutdown_flag_o; endproperty
	a_flag: assert property (p_flag) else $error("flag");
	property p_irq; $rose(shutdown_flag_o) |-> shutdown_irq_flag_o; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_hold; !restart_enable_i && shutdown_flag_o && !shutdown_clear_i |=> shutdown_flag_o; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_keep; s_held ##0 shutdown_flag_o |=> shutdown_flag_o; endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_pin; !shutdown_pin_n_i && source_enable_bits_i[0] |-> override_active_o; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_wait; $fell(shutdown_flag_o) |-> override_active_o; endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_ac; override_active_o && override_level_ac_i == shutdown_pkg::lvl_high |-> out_a_o && out_a_oe_o; endproperty
	a_ac: assert property (p_ac) else $error("ac");
endmodule
bind waveform_auto_shutdown shutdown_chk u_chk
(
	.clock_i(clock_i),
	.rst_i(rst_i),
	.shutdown_pin_n_i(shutdown_pin_n_i),
	.cmp1_out_n_i(cmp1_out_n_i),
	.source_enable_bits_i(source_enable_bits_i),
	.override_level_ac_i(override_level_ac_i),
	.restart_enable_i(restart_enable_i),
	.shutdown_set_i(shutdown_set_i),
	.shutdown_clear_i(shutdown_clear_i),
	.shutdown_flag_o(shutdown_flag_o),
	.shutdown_irq_flag_o(shutdown_irq_flag_o),
	.override_active_o(override_active_o),
	.out_a_o(out_a_o),
	.out_a_oe_o(out_a_oe_o)
);

// ### verification/test_waveform_auto_shutdown.sv
`timescale 1ns/100ps
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module test_waveform_auto_shutdown;
	logic clock_i = 1'h0, rst_i = 1'h1, ss = 1'h0, sc = 1'h0, ic = 1'h0, ren = 1'h0, p = 1'h0, d, fl, irq, ov, mf;
	logic [3:0] w = 4'h0, n = 4'h0, o, e;
	logic [5:0] en = 6'h00, f = 6'h00, s, s1, s2;
	logic [1:0] bd = 2'h0, ac = 2'h0, c;
	integer seed = 32'h614431d0, bad_count = 0, checks_done = 0, i;
	always #20 clock_i = ~clock_i;
	fault_stage_model pm (.fault_i(f), .pulse_i(p), .src_n_o(s), .data_o(d));
	waveform_auto_shutdown uut (.clock_i, .rst_i, .wave_a_i(w[0]), .wave_b_i(w[1]), .wave_c_i(w[2]), .wave_d_i(w[3]),
		.data_in_i(d), .inactive_a_i(n[0]), .inactive_b_i(n[1]), .inactive_c_i(n[2]), .inactive_d_i(n[3]),
		.shutdown_pin_n_i(s[0]), .tmr2_post_n_i(s[1]), .tmr4_post_n_i(s[2]), .tmr6_post_n_i(s[3]),
		.cmp1_out_n_i(s[4]), .cmp2_out_n_i(s[5]), .source_enable_bits_i(en), .override_level_bd_i(bd),
		.override_level_ac_i(ac), .restart_enable_i(ren), .shutdown_set_i(ss), .shutdown_clear_i(sc),
		.irq_clear_i(ic), .shutdown_flag_o(fl), .shutdown_irq_flag_o(irq), .override_active_o(ov),
		.out_a_o(o[0]), .out_a_oe_o(e[0]), .out_b_o(o[1]), .out_b_oe_o(e[1]), .out_c_o(o[2]), .out_c_oe_o(e[2]),
		.out_d_o(o[3]), .out_d_oe_o(e[3]));
	// model flag sees faults through two sync stages
	always @(posedge clock_i or posedge rst_i)
		if (rst_i)
			{s2, s1, mf} = 13'h1ffe;
		else
		begin
			mf = ss || (~s2 & en) != 6'h00 || (mf && !ren && !sc);
			{s2, s1} = {s1, s};
		end
	task automatic step(input integer k);
		repeat (k) @(negedge clock_i);
	endtask
	task automatic outs(input logic x);
		for (int k = 0; k < 4; k++)
		begin
			c = k[0] ? bd : ac;
			`chk({o[k] & e[k], e[k]}, !x ? {w[k], 1'h1} : c == 2'h0 ? {n[k], 1'h1} : {c == 2'h3, c != 2'h1})
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		step(16);
		rst_i = 1'h0;
		{w, n} = 8'($random(seed));
		step(2);
		outs(1'h0);
		ss = 1'h1;
		#1 `chk(ov, 1'h1)
		for (i = 0; i < 16; i++)
		begin
			step(1);
			ss = 1'h0;
			{bd, ac} = i[3:0];
			{w, n} = 8'($random(seed));
			#1 outs(1'h1);
			`chk(fl, mf)
		end
		`chk(irq, 1'h1)
		step(1);
		{sc, ic} = 2'h3;
		step(2);
		{sc, ic} = 2'h0;
		`chk({fl, irq, ov}, 3'h1)
		p = 1'h1;
		step(5);
		outs(1'h0);
		for (i = 0; i < 6; i++)
		begin
			p = 1'h0;
			f[i] = 1'h1;
			step(4);
			`chk(ov, 1'h0)
			en[i] = 1'h1;
			#1 `chk(ov, 1'h1)
			step(4);
			`chk(irq, 1'h1)
			{sc, ic} = 2'h3;
			step(2);
			`chk({fl, irq}, {mf, 1'h0})
			{sc, ic, ren} = 3'h1;
			// odd sources are switched off instead of cleared
			f[i] = i[0];
			en[i] = !i[0];
			step(4);
			`chk({fl, ov}, {mf, 1'h1})
			p = 1'h1;
			step(5);
			`chk(ov, 1'h0)
			{f, en, ren} = 13'h0;
		end
		results;
	end
	initial
	begin
		#400000;
		bad_count++;
		results;
	end
endmodule
